// [tb/hv_host_model.sv]
// Processor-side model driving the indirect command and data registers
`timescale 1ns/1ps
module hv_host_model (
  // Clock
  input wire logic sys_clk,
  // Register interface towards the device
  output logic cmd_wr,
  output logic [7:0] cmd_wdata,
  output logic dat_wr,
  output logic [7:0] dat_wdata,
  input wire logic [7:0] cmd_rdata,
  input wire logic [7:0] dat_rdata
);
  // Idle bus; released data lines show the inverse so stale values never look valid
  initial begin
    cmd_wr = 1'b0;
    cmd_wdata = 8'h00;
    dat_wr = 1'b0;
    dat_wdata = 8'h00;
  end
  // Bounded wait for busy to clear; a hang shows up as ok low
  task automatic wait_idle(output bit ok);
    int n;
    n = 0;
    while (cmd_rdata[0] !== 1'b0 && n < 1100) begin
      @(posedge sys_clk) #1;
      n++;
    end
    ok = (n < 1100);
  endtask : wait_idle
  // One command, then bounded polling of busy before anything is read back
  task automatic issue(input logic [7:0] cmd, output bit ok);
    @(posedge sys_clk) #1;
    cmd_wr = 1'b1;
    cmd_wdata = cmd;
    @(posedge sys_clk) #1;
    cmd_wr = 1'b0;
    cmd_wdata = ~cmd;
    wait_idle(ok);
  endtask : issue
  // A command, then a second command and a data load while busy; the device ignores both
  task automatic intrude(input logic [7:0] cmd, input logic [7:0] cmd2, input logic [7:0] v,
                         output bit ok);
    @(posedge sys_clk) #1;
    cmd_wr = 1'b1;
    cmd_wdata = cmd;
    @(posedge sys_clk) #1;
    cmd_wdata = cmd2;
    dat_wr = 1'b1;
    dat_wdata = v;
    @(posedge sys_clk) #1;
    cmd_wr = 1'b0;
    cmd_wdata = ~cmd2;
    dat_wr = 1'b0;
    dat_wdata = ~v;
    wait_idle(ok);
  endtask : intrude
  // Load data first, then the write command
  task automatic write_reg(input logic [2:0] a, input logic [7:0] v, output bit ok);
    @(posedge sys_clk) #1;
    dat_wr = 1'b1;
    dat_wdata = v;
    @(posedge sys_clk) #1;
    dat_wr = 1'b0;
    dat_wdata = ~v;
    issue({3'h0, 1'b1, a, 1'b0}, ok);
  endtask : write_reg
  // Read result is taken from the data register once busy is low or the bounded wait runs out
  task automatic read_reg(input logic [2:0] a, output logic [7:0] v, output bit ok);
    issue({3'h0, 1'b0, a, 1'b0}, ok);
    v = dat_rdata;
  endtask : read_reg
endmodule : hv_host_model

// [tb/hv_monitor_monitor.sv]
// Port-level assertion checker for the high-voltage monitor
`timescale 1ns/1ps
module hv_monitor_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Observed ports
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_rdata,
  input wire logic [7:0] dat_rdata,
  input wire logic [7:0] config_first,
  input wire logic [7:0] config_second
);
  logic [10:0] run_q;
  wire busy = cmd_rdata[0];
  wire rd_mon = (cmd_rdata[4:1] == 4'h2);
  // Busy run length, kept in a counter since the hold is far too long to unroll
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= 11'h000;
    end else begin
      run_q <= busy ? run_q + 11'h001 : 11'h000;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_held; busy ##1 busy; endsequence
  sequence s_mon_done; $fell(busy) && rd_mon; endsequence
  a_busy_start: assert property (cmd_wr && !busy |=> busy)
    else $error("busy did not rise after a command");
  a_busy_length: assert property ($fell(busy) |-> run_q == 11'h3E8)
    else $error("busy length is not 1000 cycles");
  a_busy_bound: assert property (busy |-> run_q < 11'h3E8)
    else $error("busy held too long");
  a_cfg_quiet: assert property (!busy |=> $stable(config_first) && $stable(config_second))
    else $error("config changed outside a transfer");
  a_data_hold: assert property (s_held |-> $stable(dat_rdata))
    else $error("data register moved during a transfer");
  a_cmd_latched: assert property (s_held |-> $stable(cmd_rdata[4:1]))
    else $error("command changed while busy");
  a_reserved_zero: assert property (s_mon_done |-> !dat_rdata[5] && !dat_rdata[1])
    else $error("reserved monitor bits set");
  a_gated_bits: assert property (s_mon_done |->
    (config_second[4] || !dat_rdata[7]) && (config_first[2] || !dat_rdata[3]))
    else $error("gated monitor bit set while disabled");
endmodule : hv_monitor_monitor
bind hv_monitor hv_monitor_monitor hv_monitor_monitor_inst (.sys_clk, .nrst, .cmd_wr,
  .cmd_rdata, .dat_rdata, .config_first, .config_second);

// [tb/hv_monitor_tb.sv]
// Self-checking bench for the high-voltage monitor register
`timescale 1ns/1ps
module hv_monitor_tb;
  logic sys_clk, nrst, cmd_wr, dat_wr;
  logic [7:0] cmd_wdata, cmd_rdata, dat_wdata, dat_rdata, config_first, config_second;
  logic wake_pin, thermal_shutdown, buffer_enabled, supply_low, lin_short, wake_short;
  int n_fail = 0;
  int cmp_count = 0;
  bit xfer_ok;
  hv_monitor hv_monitor_inst (.sys_clk, .nrst, .cmd_wr, .cmd_wdata, .cmd_rdata, .dat_wr,
    .dat_wdata, .dat_rdata, .wake_pin, .thermal_shutdown, .buffer_enabled, .supply_low,
    .lin_short, .wake_short, .config_first, .config_second);
  hv_host_model hv_host_model_inst (.sys_clk, .cmd_wr, .cmd_wdata, .dat_wr, .dat_wdata,
    .cmd_rdata, .dat_rdata);
  // Final report and the single end of the run
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // A timed-out transfer counts as a mismatch and ends the run
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input bit ok);
    cmp_count++;
    if (!ok || got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
    if (!ok) give_verdict();
  endtask : check
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] v;
    bit ok;
    hv_host_model_inst.read_reg(a, v, ok);
    check(v, exp, ok);
  endtask : rd
  // After a write the command register shows the latched request with busy low
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    bit ok;
    hv_host_model_inst.write_reg(a, v, ok);
    check(cmd_rdata, {3'h0, 1'b1, a, 1'b0}, ok);
  endtask : wr
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    {wake_pin, thermal_shutdown, buffer_enabled, supply_low, lin_short, wake_short} = 6'h00;
    nrst = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 nrst = 1'b1;
    check(cmd_rdata, 8'h00, 1'b1);
    rd(3'h2, 8'h00);
    $display("test reset done");
    @(posedge sys_clk) #1;
    {wake_pin, thermal_shutdown, buffer_enabled} = 3'h7;
    rd(3'h2, 8'h50);
    wr(3'h1, 8'h10);
    check(config_second, 8'h10, 1'b1);
    rd(3'h2, 8'hD0);
    $display("test live bits done");
    wr(3'h0, 8'h04);
    check(config_first, 8'h04, 1'b1);
    rd(3'h2, 8'hD8);
    @(posedge sys_clk) #1;
    supply_low = 1'b1;
    @(posedge sys_clk) #1;
    supply_low = 1'b0;
    rd(3'h2, 8'hD0);
    wr(3'h0, 8'h04);
    rd(3'h2, 8'hD8);
    $display("test low supply done");
    @(posedge sys_clk) #1;
    {lin_short, wake_short} = 2'h3;
    @(posedge sys_clk) #1;
    {lin_short, wake_short} = 2'h0;
    rd(3'h2, 8'hDD);
    wr(3'h2, 8'h00);
    rd(3'h2, 8'hDD);
    wr(3'h1, 8'h18);
    rd(3'h2, 8'hD8);
    rd(3'h5, 8'h00);
    $display("test shorts done");
    @(posedge sys_clk) #1;
    wake_pin = 1'b0;
    hv_host_model_inst.intrude(8'h04, 8'h12, 8'h00, xfer_ok);
    check(dat_rdata, 8'h58, xfer_ok);
    check(config_second, 8'h18, 1'b1);
    check(cmd_rdata, 8'h04, 1'b1);
    $display("test refused done");
    give_verdict();
  end
endmodule : hv_monitor_tb

// [verilog/hv_monitor.sv]
// High-voltage monitor status register behind the indirect command/data interface
//
// Summary of operation
// - Eight-bit read-only monitor register shows live high-voltage status, reset value 0x00.
// - Monitor is reached only by indirect command; contents return in data register.
// - Bit 7 follows the wake pin once wake I/O mode is enabled.
// - Bit 6 reads 1 while a thermal shutdown has occurred, else 0.
// - Bit 4 reads 1 while the voltage-channel input buffer is enabled.
// - When enabled, bit 3 reads 0 after supply dropped below 2.1V, else 1.
// - Low-supply indication is cleared only by re-enabling the low-supply function.
// - Bit 2 latches a LIN short; writing second config bit 3 clears it.
// - Bit 0 reads 1 after the wake driver saw a short circuit.
// - Busy stays set for the 10us transfer; software polls it before reading data.
`timescale 1ns/1ps
module hv_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Command register
  input wire logic cmd_wr,
  input wire logic [hv_monitor_pkg::REG_W-1:0] cmd_wdata,
  output logic [hv_monitor_pkg::REG_W-1:0] cmd_rdata,
  // Data register
  input wire logic dat_wr,
  input wire logic [hv_monitor_pkg::REG_W-1:0] dat_wdata,
  output logic [hv_monitor_pkg::REG_W-1:0] dat_rdata,
  // High-voltage circuit status inputs
  input wire logic wake_pin,
  input wire logic thermal_shutdown,
  input wire logic buffer_enabled,
  input wire logic supply_low,
  input wire logic lin_short,
  input wire logic wake_short,
  // Configuration registers towards the high-voltage circuits
  output logic [hv_monitor_pkg::REG_W-1:0] config_first,
  output logic [hv_monitor_pkg::REG_W-1:0] config_second
);
  import hv_monitor_pkg::*;

  // Sequencer and latched command
  xfer_state_t state_q;
  xfer_state_t state_d;
  logic [CMD_ADDR_W-1:0] addr_q;
  logic write_q;
  logic [REG_W-1:0] dat_q;
  logic [REG_W-1:0] dat_d;

  // Configuration and status storage
  logic [REG_W-1:0] cfg_first_q;
  logic [REG_W-1:0] cfg_second_q;
  logic [REG_W-1:0] high_voltage_monitor_q;
  logic [REG_W-1:0] mon_d;
  logic low_seen_q;
  logic [N_STICKY-1:0] sticky_q;

  // Decoded strobes
  logic idle;
  logic cmd_take;
  logic dat_take;
  logic xfer_done;
  logic wr_first;
  logic wr_second;
  logic rearm;
  logic supply_rearm;
  logic [N_STICKY-1:0] sticky_set;
  logic [REG_W-1:0] read_sel;

  hv_xfer_if xfer ();

  hv_xfer_timer u_timer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .xfer(xfer)
  );

  // Commands and data writes are only taken while no transfer runs
  assign idle = (state_q == ST_IDLE) && !xfer.busy;
  assign cmd_take = cmd_wr && idle;
  assign dat_take = dat_wr && idle;
  assign xfer.start = cmd_take;
  assign xfer_done = (state_q == ST_RUN) && xfer.done;

  // Writes land at the end of the transfer, as the serial link would deliver them
  assign wr_first = xfer_done && write_q && (addr_q == ADDR_CFG_FIRST);
  assign wr_second = xfer_done && write_q && (addr_q == ADDR_CFG_SECOND);
  assign rearm = wr_second && dat_q[CFG2_DRIVER_REARM];
  assign supply_rearm = wr_first && dat_q[CFG1_LOW_SUPPLY_EN];

  // Read selection; the monitor address is the only path to its contents
  assign read_sel = (addr_q == ADDR_CFG_FIRST) ? cfg_first_q :
                    (addr_q == ADDR_CFG_SECOND) ? cfg_second_q :
                    (addr_q == ADDR_MONITOR) ? high_voltage_monitor_q :
                    MON_RESET;

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cmd_take) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (xfer.done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Data register next value; a write to the monitor leaves it untouched
  always_comb begin
    dat_d = dat_q;
    if (dat_take) begin
      dat_d = dat_wdata;
    end else if (xfer_done && !write_q) begin
      dat_d = read_sel;
    end
  end

  // Sequencer and command latch
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      addr_q <= '0;
      write_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (cmd_take) begin
        addr_q <= cmd_wdata[CMD_ADDR_LSB +: CMD_ADDR_W];
        write_q <= cmd_wdata[CMD_WRITE_BIT];
      end
    end
  end

  // Data register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dat_q <= DAT_RESET;
    end else begin
      dat_q <= dat_d;
    end
  end

  // Configuration registers; the monitor address has no writable store
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_first_q <= CFG_RESET;
      cfg_second_q <= CFG_RESET;
    end else begin
      if (wr_first) begin
        cfg_first_q <= dat_q;
      end
      if (wr_second) begin
        cfg_second_q <= dat_q;
      end
    end
  end

  // Low-supply latch: a drop in the same cycle as a re-enable still wins
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      low_seen_q <= 1'b0;
    end else if (supply_low) begin
      low_seen_q <= 1'b1;
    end else if (supply_rearm) begin
      low_seen_q <= 1'b0;
    end
  end

  // Fault flag sources: entry 0 is the wake short, entry 1 the LIN short
  assign sticky_set[0] = wake_short;
  assign sticky_set[1] = lin_short;

  // Sticky fault flags; set beats the re-arm clear so no event is lost
  generate
    for (genvar i = 0; i < N_STICKY; i++) begin : g_sticky
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          sticky_q[i] <= 1'b0;
        end else if (sticky_set[i]) begin
          sticky_q[i] <= 1'b1;
        end else if (rearm) begin
          sticky_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Monitor image; reserved positions are tied low
  always_comb begin
    mon_d = MON_RESET;
    mon_d[MON_WAKE_PIN] = wake_pin && cfg_second_q[CFG2_WAKE_IO_EN];
    mon_d[MON_OVER_TEMP] = thermal_shutdown;
    mon_d[MON_BUF_EN] = buffer_enabled;
    mon_d[MON_SUPPLY_OK] = cfg_first_q[CFG1_LOW_SUPPLY_EN] && !low_seen_q;
    mon_d[MON_LIN_SHORT] = sticky_q[1];
    mon_d[MON_WAKE_SHORT] = sticky_q[0];
  end

  // Monitor register is refreshed every cycle from hardware only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      high_voltage_monitor_q <= MON_RESET;
    end else begin
      high_voltage_monitor_q <= mon_d;
    end
  end

  // Register read-back; busy is decoded from the state flop and the timer's busy flag
  always_comb begin
    cmd_rdata = '0;
    cmd_rdata[CMD_BUSY_BIT] = !idle;
    cmd_rdata[CMD_ADDR_LSB +: CMD_ADDR_W] = addr_q;
    cmd_rdata[CMD_WRITE_BIT] = write_q;
  end

  assign dat_rdata = dat_q;
  assign config_first = cfg_first_q;
  assign config_second = cfg_second_q;
endmodule : hv_monitor

// [verilog/hv_monitor_pkg.sv]
// Constants and types shared by the high-voltage monitor block
package hv_monitor_pkg;
  // Clock and transfer timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int XFER_TIME_NS = 10000;
  localparam int XFER_CYCLES = XFER_TIME_NS / CLK_PERIOD_NS;
  localparam int XFER_CNT_W = 10;
  localparam logic [XFER_CNT_W-1:0] XFER_LAST = XFER_CNT_W'(XFER_CYCLES - 1);

  // Register width and reset values
  localparam int REG_W = 8;
  localparam logic [REG_W-1:0] MON_RESET = 8'h00;
  localparam logic [REG_W-1:0] CFG_RESET = 8'h00;
  localparam logic [REG_W-1:0] DAT_RESET = 8'h00;

  // Monitor register bit positions
  localparam int MON_WAKE_PIN = 7;
  localparam int MON_OVER_TEMP = 6;
  localparam int MON_BUF_EN = 4;
  localparam int MON_SUPPLY_OK = 3;
  localparam int MON_LIN_SHORT = 2;
  localparam int MON_WAKE_SHORT = 0;

  // Configuration bit positions
  localparam int CFG1_LOW_SUPPLY_EN = 2;
  localparam int CFG2_DRIVER_REARM = 3;
  localparam int CFG2_WAKE_IO_EN = 4;

  // Command register layout
  localparam int CMD_BUSY_BIT = 0;
  localparam int CMD_ADDR_LSB = 1;
  localparam int CMD_ADDR_W = 3;
  localparam int CMD_WRITE_BIT = 4;

  // Indirect register addresses
  localparam logic [CMD_ADDR_W-1:0] ADDR_CFG_FIRST = 3'h0;
  localparam logic [CMD_ADDR_W-1:0] ADDR_CFG_SECOND = 3'h1;
  localparam logic [CMD_ADDR_W-1:0] ADDR_MONITOR = 3'h2;

  // Sticky fault flags kept in hardware
  localparam int N_STICKY = 2;

  // Transfer sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } xfer_state_t;
endpackage : hv_monitor_pkg

// [verilog/hv_xfer_if.sv]
// Handshake between the transfer sequencer and its latency timer
`timescale 1ns/1ps
interface hv_xfer_if;
  logic start;
  logic busy;
  logic done;

  modport timer (
    input start,
    output busy,
    output done
  );

  modport ctrl (
    output start,
    input busy,
    input done
  );
endinterface : hv_xfer_if

// [verilog/hv_xfer_timer.sv]
// Latency timer for one indirect high-voltage transfer
`timescale 1ns/1ps
module hv_xfer_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Sequencer handshake
  hv_xfer_if.timer xfer
);
  import hv_monitor_pkg::*;

  logic running_q;
  logic [XFER_CNT_W-1:0] cnt_q;
  logic at_last;

  // The serial link latency is fixed, so a plain count stands in for it
  assign at_last = running_q && (cnt_q == XFER_LAST);
  assign xfer.done = at_last;
  assign xfer.busy = running_q;

  // Count the transfer window
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      running_q <= 1'b0;
      cnt_q <= '0;
    end else if (xfer.start && !running_q) begin
      running_q <= 1'b1;
      cnt_q <= '0;
    end else if (at_last) begin
      running_q <= 1'b0;
    end else if (running_q) begin
      cnt_q <= cnt_q + XFER_CNT_W'(1);
    end
  end
endmodule : hv_xfer_timer
